// [and_branch_defines.vh]
// constants for the and / branch decode block
`ifndef AND_BRANCH_DEFINES_VH
`define AND_BRANCH_DEFINES_VH

// ----------------------------------------
// opcodes and field patterns
// ----------------------------------------
`define OP_AND_NIBBLE      10'h018
`define OP_INDEXED_LONG    10'h010
`define OP_SHORT_TOP       3'h3
`define OP_LONG_TOP        5'h07
`define OP_SECOND_TOP      2'h2
`define OP_INDEXED_GAP     2'h0

// ----------------------------------------
// widths, reset values and default page limit
// ----------------------------------------
`define PC_PAGE_W          6
`define PC_LOW_W           7
`define PC_PAGE_RST        6'h00
`define PC_LOW_RST         7'h00
`define ACC_RST            4'h0
`define PAGE_MAX_DEFAULT   6'h3f

`endif

// [opcode_class.v]
// one-word opcode classifier for the and / branch decode block
`include "and_branch_defines.vh"

module opcode_class (
  input  wire [9:0] word_i,
  output wire       is_and_o,
  output wire       is_short_o,
  output wire       is_long_o,
  output wire       is_indexed_o,
  output wire       is_second_o
);

  assign is_and_o     = (word_i == `OP_AND_NIBBLE);     // [RULE1]
  assign is_short_o   = (word_i[9:7] == `OP_SHORT_TOP);  // [RULE3]
  assign is_long_o    = (word_i[9:5] == `OP_LONG_TOP);   // [RULE4]
  assign is_indexed_o = (word_i == `OP_INDEXED_LONG);   // [RULE7]
  assign is_second_o  = (word_i[9:8] == `OP_SECOND_TOP); // [RULE5]

endmodule

// [and_and_branch_decode.v]
// decode and execute of nibble and plus three branch forms
//
// Behaviour
// [RULE1] and opcode 018 hex, one word, one cycle
// [RULE2] accumulator anded with pointed ram nibble
// [RULE3] top bits 011: in-page branch, page kept
// [RULE4] long branch first word 00111 plus p4..p0
// [RULE5] second word 10, p5, then a6..a0
// [RULE6] long branch loads page and low, two cycles
// [RULE7] indexed: 010 hex, then 10 p5p4 00 p3..p0
// [RULE8] indexed target page p, low from d and acc
// [RULE9] indexed branch two words, two cycles
// [RULE10] software keeps page within implemented rom
// [RULE11] carry and skip untouched; pc advances after and
`include "and_branch_defines.vh"

module and_and_branch_decode #(
  parameter [`PC_PAGE_W-1:0] PAGE_MAX = `PAGE_MAX_DEFAULT
) (
  input  wire                  clk_i,
  input  wire                  sys_rst_i,
  input  wire                  cycle_en_i,
  input  wire [9:0]            rom_word_i,
  input  wire [3:0]            pointed_ram_nibble_i,
  input  wire [2:0]            reg_d_i,
  input  wire                  carry_flag_i,
  output reg  [`PC_PAGE_W-1:0] pc_page_field_o,
  output reg  [`PC_LOW_W-1:0]  pc_in_page_field_o,
  output reg  [3:0]            acc_o,
  output wire                  carry_flag_o,
  output wire                  skip_next_o,
  output wire                  second_word_o,
  output reg                   bad_page_o
);

  // ----------------------------------------
  // states
  // ----------------------------------------
  localparam [2:0] ST_FETCH   = 3'b001;
  localparam [2:0] ST_LONG2   = 3'b010;
  localparam [2:0] ST_INDEX2  = 3'b100;

  reg  [2:0]            state_q;
  reg  [2:0]            state_d;
  reg  [4:0]            page_lo_q;
  reg  [4:0]            page_lo_d;
  reg  [`PC_PAGE_W-1:0] page_d;
  reg  [`PC_LOW_W-1:0]  low_d;
  reg  [3:0]            acc_d;
  reg                   bad_d;
  reg  [`PC_PAGE_W-1:0] tgt_page;

  wire is_and;
  wire is_short;
  wire is_long;
  wire is_indexed;
  wire is_second;

  wire [3:0] and_nibble;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  // one bound test for both two-word forms keeps them in step
  function page_over;
    input [`PC_PAGE_W-1:0] page;
    input [`PC_PAGE_W-1:0] limit;
    begin
      page_over = (page > limit);
    end
  endfunction

  // second word of either long form must open with 10
  function second_bad;
    input       second_ok;
    input [1:0] gap;
    input       check_gap;
    begin
      second_bad = ~second_ok | (check_gap & (gap != `OP_INDEXED_GAP));
    end
  endfunction

  function [`PC_PAGE_W-1:0] long_page;
    input [9:0] word;
    input [4:0] low_part;
    begin
      long_page = {word[7], low_part};
    end
  endfunction

  function [`PC_PAGE_W-1:0] indexed_page;
    input [9:0] word;
    begin
      indexed_page = {word[7:6], word[3:0]};
    end
  endfunction

  // ----------------------------------------
  // nibble and datapath
  // ----------------------------------------
  genvar gi;

  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_and_bit
      assign and_nibble[gi] = acc_o[gi] & pointed_ram_nibble_i[gi];  // [RULE2]
    end
  endgenerate

  // ----------------------------------------
  // classifier
  // ----------------------------------------
  opcode_class u_class (
    .word_i       (rom_word_i),
    .is_and_o     (is_and),
    .is_short_o   (is_short),
    .is_long_o    (is_long),
    .is_indexed_o (is_indexed),
    .is_second_o  (is_second)
  );

  // none of these instructions touch carry or skip
  assign carry_flag_o  = carry_flag_i;  // [RULE11]
  assign skip_next_o   = 1'b0;          // [RULE11]
  assign second_word_o = (state_q != ST_FETCH);

  // ----------------------------------------
  // next state and pc
  // ----------------------------------------
  always @*
  begin
    state_d   = state_q;
    page_lo_d = page_lo_q;
    page_d    = pc_page_field_o;
    low_d     = pc_in_page_field_o;
    acc_d     = acc_o;
    bad_d     = bad_page_o;
    tgt_page  = pc_page_field_o;
    case (state_q)
      ST_FETCH:
      begin
        // default advance; wraps within the page
        low_d = pc_in_page_field_o + 7'h01;  // [RULE11]
        if (is_and)
        begin
          acc_d = and_nibble;  // [RULE2]
        end
        else if (is_short)
        begin
          low_d = rom_word_i[6:0];  // [RULE3]
        end
        else if (is_long)
        begin
          page_lo_d = rom_word_i[4:0];  // [RULE4]
          state_d   = ST_LONG2;
        end
        else if (is_indexed)
        begin
          state_d = ST_INDEX2;  // [RULE7]
        end
      end
      ST_LONG2:
      begin
        // malformed second word is treated as the branch anyway
        tgt_page = long_page(rom_word_i, page_lo_q);  // [RULE5]
        page_d   = tgt_page;                          // [RULE6]
        low_d    = rom_word_i[6:0];                   // [RULE6]
        bad_d    = page_over(tgt_page, PAGE_MAX)
                   | second_bad(is_second, 2'h0, 1'b0);  // [RULE10]
        state_d  = ST_FETCH;
      end
      ST_INDEX2:
      begin
        tgt_page = indexed_page(rom_word_i);  // [RULE7]
        page_d   = tgt_page;                  // [RULE8]
        low_d    = {reg_d_i, acc_o};          // [RULE8]
        bad_d    = page_over(tgt_page, PAGE_MAX)
                   | second_bad(is_second, rom_word_i[5:4], 1'b1);  // [RULE10]
        state_d  = ST_FETCH;  // [RULE9]
      end
      default:
      begin
        state_d = ST_FETCH;
      end
    endcase
  end

  // ----------------------------------------
  // sequencer registers
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q   <= ST_FETCH;
      page_lo_q <= 5'h00;
    end
    else if (cycle_en_i)
    begin
      // one instruction cycle per enable
      state_q   <= state_d;  // [RULE6]
      page_lo_q <= page_lo_d;
    end
  end

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pc_page_field_o    <= `PC_PAGE_RST;
      pc_in_page_field_o <= `PC_LOW_RST;
    end
    else if (cycle_en_i)
    begin
      pc_page_field_o    <= page_d;
      pc_in_page_field_o <= low_d;
    end
  end

  // ----------------------------------------
  // accumulator and page flag
  // ----------------------------------------
  // page flag is sticky until the next two-word branch rewrites it
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      acc_o      <= `ACC_RST;
      bad_page_o <= 1'b0;
    end
    else if (cycle_en_i)
    begin
      acc_o      <= acc_d;  // [RULE1]
      bad_page_o <= bad_d;
    end
  end

endmodule

// [rom_model.sv]
// program rom partner: ten-bit words by page and in-page address
module rom_model (
  input  wire [5:0] page_i,
  input  wire [6:0] low_i,
  output wire [9:0] word_o
);
  timeunit 1ns / 1ns;
  reg [9:0] mem [0:8191];
  // six-bit page field, so no fetch leaves the largest rom
  assign word_o = mem[{page_i, low_i}];
endmodule

// [abd_monitor.sv]
// checker for the and / branch decode block
module abd_mon (
  input wire       clk_i,
  input wire       sys_rst_i,
  input wire       cycle_en_i,
  input wire       carry_flag_i,
  input wire       carry_flag_o,
  input wire       skip_next_o,
  input wire       second_word_o,
  input wire [9:0] rom_word_i,
  input wire [3:0] pointed_ram_nibble_i,
  input wire [3:0] acc_o,
  input wire [2:0] reg_d_i,
  input wire [5:0] pc_page_field_o,
  input wire [6:0] pc_in_page_field_o
);
  timeunit 1ns / 1ns;
  wire [9:0]  w = rom_word_i;
  wire [12:0] pc = {pc_page_field_o, pc_in_page_field_o};
  reg  [9:0]  w1_q;
  // one-cycle-old copies stand in for past values of part-selects
  reg  [9:0]  w_q;
  reg  [3:0]  and_q;
  reg  [5:0]  page_q;
  reg  [6:0]  low_q;
  reg  [6:0]  index_low_q;
  // kept so a second word pairs with its first
  always @(posedge clk_i) if (cycle_en_i && !second_word_o) w1_q <= w;
  always @(posedge clk_i)
  begin
    w_q         <= w;
    and_q       <= acc_o & pointed_ram_nibble_i;
    page_q      <= pc_page_field_o;
    low_q       <= pc_in_page_field_o;
    index_low_q <= {reg_d_i, acc_o};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence f_s; cycle_en_i && !second_word_o; endsequence
  sequence s_s; cycle_en_i && second_word_o; endsequence
  AST_CY: assert property (carry_flag_o == carry_flag_i && !skip_next_o)
    else $error("carry or skip changed");
  AST_AND: assert property (f_s ##0 w == 10'h018 |=>
    acc_o == and_q) else $error("and result wrong");
  AST_ADV: assert property (f_s ##0 w == 10'h018 |=>
    pc == {page_q, low_q + 7'h01}) else $error("pc not advanced after and");
  AST_B: assert property (f_s ##0 w[9:7] == 3'h3 |=>
    pc == {page_q, w_q[6:0]}) else $error("short branch target wrong");
  AST_W1: assert property (f_s ##0 (w[9:5] == 5'h07 || w == 10'h010) |=> second_word_o)
    else $error("second word not awaited");
  AST_BL: assert property (s_s ##0 w1_q[9:5] == 5'h07 |=>
    pc == {w_q[7], w1_q[4:0], w_q[6:0]}) else $error("long branch target wrong");
  AST_BLA: assert property (s_s ##0 w1_q == 10'h010 |=>
    pc == {w_q[7:6], w_q[3:0], index_low_q}) else $error("indexed branch target wrong");
  AST_TWO: assert property (s_s |=> !second_word_o)
    else $error("more than two words");
  AST_HOLD: assert property (!cycle_en_i |=> $stable({pc, acc_o}))
    else $error("state moved without enable");
endmodule
bind and_and_branch_decode abd_mon mon (
  .clk_i                (clk_i),
  .sys_rst_i            (sys_rst_i),
  .cycle_en_i           (cycle_en_i),
  .carry_flag_i         (carry_flag_i),
  .carry_flag_o         (carry_flag_o),
  .skip_next_o          (skip_next_o),
  .second_word_o        (second_word_o),
  .rom_word_i           (rom_word_i),
  .pointed_ram_nibble_i (pointed_ram_nibble_i),
  .acc_o                (acc_o),
  .reg_d_i              (reg_d_i),
  .pc_page_field_o      (pc_page_field_o),
  .pc_in_page_field_o   (pc_in_page_field_o)
);

// [and_and_branch_decode_tb.sv]
// testbench for the and / branch decode block
module and_and_branch_decode_tb;
  timeunit 1ns / 1ns;
  reg         clk_i = 1'b0;
  reg         sys_rst_i = 1'b1;
  reg         cycle_en_i = 1'b0;
  reg         carry_flag_i = 1'b1;
  reg  [2:0]  reg_d_i = 3'h5;
  reg  [3:0]  pointed_ram_nibble_i = 4'ha;
  wire [9:0]  rom_word_i;
  wire [5:0]  pc_page_field_o;
  wire [6:0]  pc_in_page_field_o;
  wire [3:0]  acc_o;
  wire        carry_flag_o;
  wire        skip_next_o;
  wire        second_word_o;
  wire        bad_page_o;
  wire [13:0] pc_sw = {pc_page_field_o, pc_in_page_field_o, second_word_o};
  wire [13:0] flags_w = {7'h00, carry_flag_o, skip_next_o, acc_o, bad_page_o};
  integer     miscompares = 0;
  integer     n_compared = 0;
  and_and_branch_decode uut (
    .clk_i                (clk_i),
    .sys_rst_i            (sys_rst_i),
    .cycle_en_i           (cycle_en_i),
    .rom_word_i           (rom_word_i),
    .pointed_ram_nibble_i (pointed_ram_nibble_i),
    .reg_d_i              (reg_d_i),
    .carry_flag_i         (carry_flag_i),
    .pc_page_field_o      (pc_page_field_o),
    .pc_in_page_field_o   (pc_in_page_field_o),
    .acc_o                (acc_o),
    .carry_flag_o         (carry_flag_o),
    .skip_next_o          (skip_next_o),
    .second_word_o        (second_word_o),
    .bad_page_o           (bad_page_o)
  );
  rom_model rom (.page_i(pc_page_field_o), .low_i(pc_in_page_field_o), .word_o(rom_word_i));
  initial forever #25 clk_i = ~clk_i;
  task chk(input string what, input [13:0] seen, input [13:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      miscompares = miscompares + 1;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // idle cycle between enables keeps each word apart; carry toggles to show it passes
  task step(input exp_bad);
    @(negedge clk_i);
    cycle_en_i   = 1'b1;
    carry_flag_i = ~carry_flag_i;
    @(negedge clk_i);
    cycle_en_i   = 1'b0;
    chk("flags", flags_w, {7'h00, carry_flag_i, 1'b0, 4'h0, exp_bad});
  endtask
  task t_and;
    step(1'b0);
    chk("pc", pc_sw, {6'h00, 7'h01, 1'b0});
    $display("and ok");
  endtask
  task t_short;
    step(1'b0);
    chk("pc", pc_sw, {6'h00, 7'h20, 1'b0});
    $display("short ok");
  endtask
  task t_long;
    step(1'b0);
    chk("pc", pc_sw, {6'h00, 7'h21, 1'b1});
    step(1'b0);
    chk("pc", pc_sw, {6'h25, 7'h43, 1'b0});
    $display("long ok");
  endtask
  task t_indexed;
    step(1'b0);
    chk("pc", pc_sw, {6'h25, 7'h44, 1'b1});
    step(1'b0);
    chk("pc", pc_sw, {6'h37, 7'h50, 1'b0});
    $display("indexed ok");
  endtask
  // malformed second word still branches and raises the page flag
  task t_malformed;
    step(1'b0);
    chk("pc", pc_sw, {6'h37, 7'h51, 1'b1});
    step(1'b1);
    chk("pc", pc_sw, {6'h01, 7'h43, 1'b0});
    $display("malformed ok");
  endtask
  // reset in mid-run clears pc and page flag; first enable after it counts
  task t_reset;
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    sys_rst_i = 1'b0;
    step(1'b0);
    chk("pc", pc_sw, {6'h00, 7'h01, 1'b0});
    $display("reset ok");
  endtask
  task summarize;
    $display("%0d compared %0d bad", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial
  begin
    rom.mem[13'h0000] = 10'h018;
    rom.mem[13'h0001] = 10'h1a0;
    rom.mem[13'h0020] = 10'h0e5;
    rom.mem[13'h0021] = 10'h2c3;
    rom.mem[13'h12c3] = 10'h010;
    rom.mem[13'h12c4] = 10'h2c7;
    rom.mem[13'h1bd0] = 10'h0e1;
    rom.mem[13'h1bd1] = 10'h043;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_and;
    t_short;
    t_long;
    t_indexed;
    t_malformed;
    t_reset;
    summarize;
  end
endmodule
